/* shared/ghp_pkg.sv */
// package of constants for the glyph ram host port
// assumes one 40 MHz clock and a synchronous active-high reset
// Operation
// RULE1 - character code bits 2:0 become glyph ram address bits 5:3
// RULE2 - glyph ram address bits 2:0 pick the pattern line
// RULE3 - eighth pattern line is cursor line, shown as data OR cursor
// RULE4 - software should keep eighth line data zero
// RULE5 - bit 4 of eighth line lights its dot regardless of cursor
// RULE6 - row dots map to data bits 4:0, bit 4 leftmost
// RULE7 - user glyphs only when code bits 7:4 are zero, else fixed font
// RULE8 - code bit 3 ignored when picking a user glyph
// RULE9 - glyph bit one lights dot, zero leaves it dark
// RULE10 - port serves one 8-bit or two 4-bit transfers per byte
// RULE11 - narrow mode uses upper data lines only, lower ignored; high-nibble reads still drive the whole byte on all eight lines
// RULE12 - host holds lower data lines at fixed levels in narrow mode
// RULE13 - narrow byte completes after two nibble transfers
// RULE14 - high nibble crosses first, then low nibble
// RULE15 - host polls busy before high nibble only
// RULE16 - wide mode moves each byte in one cycle on all lines
// RULE17 - strap shorted selects serial, open selects parallel
// RULE18 - status read returns busy on bit 7, address counter bits 6:0
// RULE19 - while busy, new instructions are not accepted
// RULE20 - address counter steps by one after each ram data access
// RULE21 - nibble phase tracked, byte acted on after low nibble
// RULE22 - data length setting picks narrow or wide mode
package ghp_pkg;
    localparam int          ADDR_W        = 7;
    localparam int          GRAM_DEPTH    = 64;
    localparam int          CRAM_DEPTH    = 128;
    // instruction decode: function set 001x, data length at bit 4
    localparam logic [7:0]  CMD_FUNC_SET  = 8'h20;
    localparam logic [7:0]  CMD_ENTRY     = 8'h04;
    localparam logic [7:0]  CMD_GRAM_ADDR = 8'h40;
    localparam logic [7:0]  CMD_CRAM_ADDR = 8'h80;
    localparam int          FUNC_WIDE_BIT = 4;
    localparam int          ENTRY_INC_BIT = 1;
    localparam int          CURSOR_LINE   = 7;
    localparam int          CURSOR_DOT    = 4;
    localparam logic        RST_WIDE      = 1'b1;
    localparam logic        RST_INC       = 1'b1;
    localparam int          BUSY_NS       = 1000;
    localparam int          CLK_MHZ       = 40;
    localparam int          BUSY_CYC      = (BUSY_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  BUSY_RST      = 8'h00;
    typedef enum logic [2:0] {
        GHP_IDLE = 3'b001,
        GHP_ACK  = 3'b010,
        GHP_DONE = 3'b100
    } ghp_wb_state_t;
endpackage

/* hdl/ghp_host_port.sv */
// glyph ram host port: character bus, glyph ram addressing, glyph rows
// assumes bus pins synchronous to clk_sys_i and a fixed font rom outside
//
`timescale 1ns/100ps
module ghp_host_port #(
    parameter int BUSY_CYCLES = ghp_pkg::BUSY_CYC
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    // parallel character bus, one strobe per nibble or byte
    input  wire logic       bus_stb_i,
    input  wire logic       bus_we_i,
    input  wire logic       register_select_line_i,
    input  wire logic [7:0] full_data_lines_i,
    output logic      [7:0] full_data_lines_o,
    output logic            full_data_lines_oe_o,
    // board strap, high when shorted
    input  wire logic       serial_select_strap_i,
    output logic            serial_mode_o,
    // display fetch side
    input  wire logic [7:0] disp_code_i,
    input  wire logic [2:0] disp_line_i,
    input  wire logic       disp_cursor_i,
    input  wire logic [4:0] font_row_i,
    output logic      [4:0] disp_dots_o,
    output logic            busy_indicator_o
);
    logic [7:0] user_glyph_ram [ghp_pkg::GRAM_DEPTH];
    logic [7:0] char_code_ram  [ghp_pkg::CRAM_DEPTH];

    logic [6:0]  address_counter_reg_ff, nxt_address_counter_reg;
    logic        gram_sel_ff, nxt_gram_sel;
    logic        wide_ff, nxt_wide;
    logic        inc_ff, nxt_inc;
    logic        hi_phase_ff, nxt_hi_phase;
    logic [3:0]  hi_nib_ff, nxt_hi_nib;
    logic [7:0]  data_holding_reg_ff, nxt_data_holding_reg;
    logic [15:0] busy_cnt_ff, nxt_busy_cnt;
    logic [7:0]  rd_o_ff, nxt_rd_o;
    logic        rd_oe_ff, nxt_rd_oe;
    logic [4:0]  dots_ff, nxt_dots;
    logic        serial_ff, nxt_serial;
    logic        busy_ind_ff, nxt_busy_ind;

    logic       byte_done;
    logic [7:0] byte_val;
    logic [7:0] instruction_holding_reg;
    logic       ram_wr, ram_rd, cmd_wr;
    logic [5:0] gaddr;
    logic [7:0] grow;
    logic       busy;

    assign busy = (busy_cnt_ff != 16'h0000);

    always_comb begin
        nxt_hi_phase = hi_phase_ff;
        nxt_hi_nib   = hi_nib_ff;
        byte_done    = 1'b0;
        byte_val     = full_data_lines_i;
        if (bus_stb_i && !serial_ff) begin
            if (wide_ff) begin                             // RULE10
                byte_done = 1'b1;                          // RULE16
            end else if (hi_phase_ff) begin
                nxt_hi_nib   = full_data_lines_i[7:4];     // RULE11 RULE14
                nxt_hi_phase = 1'b0;
            end else begin
                byte_val     = {hi_nib_ff, full_data_lines_i[7:4]}; // RULE14
                byte_done    = 1'b1;                       // RULE13 RULE21
                nxt_hi_phase = 1'b1;
            end
        end
    end

    always_comb begin
        instruction_holding_reg = byte_val;
        cmd_wr = byte_done && bus_we_i && !register_select_line_i
                 && !busy;                                 // RULE19
        ram_wr = byte_done && bus_we_i && register_select_line_i && !busy;
        ram_rd = byte_done && !bus_we_i && register_select_line_i && !busy;
        nxt_address_counter_reg = address_counter_reg_ff;
        nxt_gram_sel = gram_sel_ff;
        nxt_wide     = wide_ff;
        nxt_inc      = inc_ff;
        nxt_busy_cnt = busy ? busy_cnt_ff - 16'h0001 : busy_cnt_ff;
        nxt_data_holding_reg = data_holding_reg_ff;
        if (cmd_wr) begin
            nxt_busy_cnt = 16'(BUSY_CYCLES);
            if (instruction_holding_reg[7]) begin
                nxt_address_counter_reg = instruction_holding_reg[6:0];
                nxt_gram_sel = 1'b0;
            end else if (instruction_holding_reg[6]) begin
                nxt_address_counter_reg =
                    {1'b0, instruction_holding_reg[5:0]};
                nxt_gram_sel = 1'b1;
            end else if (instruction_holding_reg[5]) begin
                nxt_wide = instruction_holding_reg[ghp_pkg::FUNC_WIDE_BIT];
                // RULE22
            end else if (instruction_holding_reg[2]) begin
                nxt_inc = instruction_holding_reg[ghp_pkg::ENTRY_INC_BIT];
            end
        end
        if (ram_wr || ram_rd) begin
            // RULE20
            nxt_address_counter_reg = inc_ff ? address_counter_reg_ff + 7'h01
                                             : address_counter_reg_ff - 7'h01;
            if (gram_sel_ff) begin
                nxt_address_counter_reg[6] = 1'b0;
            end
            nxt_busy_cnt = 16'(BUSY_CYCLES);
        end
        if (ram_rd) begin
            nxt_data_holding_reg = gram_sel_ff
                ? user_glyph_ram[address_counter_reg_ff[5:0]]
                : char_code_ram[address_counter_reg_ff];
        end
        // registered so the pin comes straight from a flop, same timing
        nxt_busy_ind = (nxt_busy_cnt != 16'h0000);
    end

    // bus read path: in narrow mode the nibble on the upper lines follows
    // the same high-then-low phase as writes
    always_comb begin
        nxt_rd_oe = bus_stb_i && !bus_we_i && !serial_ff;
        nxt_rd_o  = rd_o_ff;
        if (nxt_rd_oe) begin
            if (!register_select_line_i) begin
                nxt_rd_o = {busy, address_counter_reg_ff};  // RULE18
            end else if (gram_sel_ff) begin
                nxt_rd_o = user_glyph_ram[address_counter_reg_ff[5:0]];
            end else begin
                nxt_rd_o = char_code_ram[address_counter_reg_ff];
            end
            if (!wide_ff && !hi_phase_ff) begin
                nxt_rd_o = {nxt_rd_o[3:0], 4'h0};
            end
        end
    end

    always_comb begin
        gaddr = {disp_code_i[2:0], disp_line_i};           // RULE1 RULE2 RULE8
        grow  = user_glyph_ram[gaddr];
        nxt_serial = serial_select_strap_i;                // RULE17
        if (disp_code_i[7:4] == 4'h0) begin                // RULE7
            nxt_dots = grow[4:0];                          // RULE6 RULE9
        end else begin
            nxt_dots = font_row_i;
        end
        if (disp_line_i == 3'(ghp_pkg::CURSOR_LINE)) begin
            nxt_dots = nxt_dots | {5{disp_cursor_i}};      // RULE3 RULE5
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (ram_wr) begin
            if (gram_sel_ff) begin
                user_glyph_ram[address_counter_reg_ff[5:0]] <= byte_val;
            end else begin
                char_code_ram[address_counter_reg_ff] <= byte_val;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            address_counter_reg_ff <= 7'h00;
            gram_sel_ff            <= 1'b0;
            wide_ff                <= ghp_pkg::RST_WIDE;
            inc_ff                 <= ghp_pkg::RST_INC;
            hi_phase_ff            <= 1'b1;                // RULE21
            hi_nib_ff              <= 4'h0;
            data_holding_reg_ff    <= 8'h00;
            busy_cnt_ff            <= 16'h0000;
            busy_ind_ff            <= 1'b0;
            rd_o_ff                <= 8'h00;
            rd_oe_ff               <= 1'b0;
            dots_ff                <= 5'h00;
            serial_ff              <= 1'b0;
        end else begin
            address_counter_reg_ff <= nxt_address_counter_reg;
            gram_sel_ff            <= nxt_gram_sel;
            wide_ff                <= nxt_wide;
            inc_ff                 <= nxt_inc;
            hi_phase_ff            <= nxt_hi_phase;
            hi_nib_ff              <= nxt_hi_nib;
            data_holding_reg_ff    <= nxt_data_holding_reg;
            busy_cnt_ff            <= nxt_busy_cnt;
            busy_ind_ff            <= nxt_busy_ind;
            rd_o_ff                <= nxt_rd_o;
            rd_oe_ff               <= nxt_rd_oe;
            dots_ff                <= nxt_dots;
            serial_ff              <= nxt_serial;
        end
    end

    assign full_data_lines_o    = rd_o_ff;
    assign full_data_lines_oe_o = rd_oe_ff;
    assign disp_dots_o          = dots_ff;
    assign busy_indicator_o     = busy_ind_ff;
    assign serial_mode_o        = serial_ff;
endmodule // ghp_host_port

/* sim/ghp_host_model.sv */
// host model: drives the parallel character bus a byte, or in narrow mode a nibble, at a time
// assumes strobes are taken on the rising edge of clk_sys_i
`timescale 1ns/100ps
module ghp_host_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] rdata_i,
    output logic            stb_o = 1'b0,
    output logic            we_o = 1'b0,
    output logic            rs_o = 1'b0,
    output logic      [7:0] data_o = 8'h00
);
    logic narrow = 1'b0;
    task automatic xfer(input logic we, input logic rs,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys_i);
        stb_o  <= 1'b1;
        we_o   <= we;
        rs_o   <= rs;
        data_o <= d;
        @(posedge clk_sys_i);
        stb_o  <= 1'b0;
        // released lines must not keep the last value; in narrow mode the
        // lower lines stay at their fixed level
        data_o <= narrow ? {~d[7:4], d[3:0]} : ~d;
        #1 q = rdata_i;
    endtask
    // lower lines held at a fixed level in narrow mode
    task automatic op(input logic we, input logic rs,
                      input logic [7:0] d, output logic [7:0] q);
        logic [7:0] q2;
        if (narrow) begin
            xfer(we, rs, {d[7:4], 4'h5}, q);
            xfer(we, rs, {d[3:0], 4'h5}, q2);
            q = {q[7:4], q2[7:4]};
        end else begin
            xfer(we, rs, d, q);
        end
    endtask
    // bounded so that a stuck busy shows up instead of hanging
    task automatic poll(output logic ok, output logic [7:0] s);
        ok = 1'b0;
        for (int n = 0; n < 50 && !ok; n++) begin
            op(1'b0, 1'b0, 8'h00, s);
            ok = (s[7] === 1'b0);
        end
    endtask
endmodule // ghp_host_model

/* sim/ghp_props.sv */
// checker for the glyph ram host port
// assumes only the top module's ports and a sync active-high reset
`timescale 1ns/100ps
module ghp_props #(parameter int BUSY_CYCLES = 40) (
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    input wire logic       bus_stb_i,
    input wire logic       bus_we_i,
    input wire logic       register_select_line_i,
    input wire logic       serial_mode_o,
    input wire logic       full_data_lines_oe_o,
    input wire logic [7:0] disp_code_i,
    input wire logic [2:0] disp_line_i,
    input wire logic       disp_cursor_i,
    input wire logic [4:0] font_row_i,
    input wire logic [4:0] disp_dots_o,
    input wire logic       busy_indicator_o
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    // counts the cycles that busy has stood so far
    always_comb begin
        nxt_cnt = cnt_ff + 16'h0001;
        if (rst_i || !busy_indicator_o) begin
            nxt_cnt = 16'h0000;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        cnt_ff <= nxt_cnt;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_rd;
        bus_stb_i && !bus_we_i && !serial_mode_o;
    endsequence
    sequence s_wr;
        bus_stb_i && bus_we_i;
    endsequence
    property p_rd_oe;
        s_rd |=> full_data_lines_oe_o;
    endproperty
    property p_oe_cause;
        full_data_lines_oe_o |-> $past(bus_stb_i && !bus_we_i);
    endproperty
    property p_wr_no_oe;
        s_wr |=> !full_data_lines_oe_o;
    endproperty
    // ram data reads start an internal operation just as writes do
    property p_busy_cause;
        $rose(busy_indicator_o) |-> $past(bus_stb_i && !serial_mode_o
            && (bus_we_i || register_select_line_i));
    endproperty
    property p_busy_len;
        $fell(busy_indicator_o) |-> cnt_ff == 16'(BUSY_CYCLES);
    endproperty
    property p_busy_max;
        cnt_ff <= 16'(BUSY_CYCLES);
    endproperty
    property p_serial;
        serial_mode_o && bus_stb_i
            |=> !full_data_lines_oe_o && !$rose(busy_indicator_o);
    endproperty
    property p_font;
        disp_code_i[7:4] != 4'h0 && disp_line_i != 3'h7
            |=> disp_dots_o == $past(font_row_i);
    endproperty
    property p_cursor;
        disp_code_i[7:4] == 4'h0 && disp_line_i == 3'h7 && disp_cursor_i
            |=> disp_dots_o == 5'h1f;
    endproperty
    a_rd_oe: assert property (p_rd_oe)
        else $error("read not answered");
    a_oe_cause: assert property (p_oe_cause)
        else $error("stray oe");
    a_wr_no_oe: assert property (p_wr_no_oe)
        else $error("oe on write");
    a_busy_cause: assert property (p_busy_cause)
        else $error("stray busy");
    a_busy_len: assert property (p_busy_len)
        else $error("busy length");
    a_busy_max: assert property (p_busy_max)
        else $error("busy restarted");
    a_serial: assert property (p_serial)
        else $error("serial strobe taken");
    a_font: assert property (p_font)
        else $error("fixed font row wrong");
    a_cursor: assert property (p_cursor)
        else $error("cursor row wrong");
endmodule // ghp_props
bind ghp_host_port ghp_props #(.BUSY_CYCLES(BUSY_CYCLES)) props_u (
    .clk_sys_i, .rst_i, .bus_stb_i, .bus_we_i, .register_select_line_i,
    .serial_mode_o, .full_data_lines_oe_o, .disp_code_i, .disp_line_i,
    .disp_cursor_i, .font_row_i, .disp_dots_o, .busy_indicator_o);

/* sim/tb.sv */
// bench for the glyph ram host port: bus traffic, glyph rows, strap
// assumes ghp_host_model as host; a short busy time keeps the run brief
`timescale 1ns/100ps
module tb;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic serial_select_strap_i = 1'b0;
    logic [7:0] disp_code_i = 8'h00;
    logic [2:0] disp_line_i = 3'h0;
    logic disp_cursor_i = 1'b0;
    logic [4:0] font_row_i = 5'h00;
    logic bus_stb_i, bus_we_i, register_select_line_i, full_data_lines_oe_o;
    logic serial_mode_o, busy_indicator_o, ok;
    logic [7:0] full_data_lines_i, full_data_lines_o, q;
    logic [4:0] disp_dots_o;
    int mismatches = 0;
    int check_count = 0;
    ghp_host_port #(.BUSY_CYCLES(3)) dut_u (.clk_sys_i, .rst_i, .bus_stb_i,
        .bus_we_i, .register_select_line_i, .full_data_lines_i,
        .full_data_lines_o, .full_data_lines_oe_o, .serial_select_strap_i,
        .serial_mode_o, .disp_code_i, .disp_line_i, .disp_cursor_i,
        .font_row_i, .disp_dots_o, .busy_indicator_o);
    ghp_host_model host_u (.clk_sys_i, .rdata_i(full_data_lines_o),
        .stb_o(bus_stb_i), .we_o(bus_we_i), .rs_o(register_select_line_i),
        .data_o(full_data_lines_i));
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    function automatic logic [7:0] pat(input int i);
        return (i == 7) ? 8'h10 : 8'h0f - 8'(i);
    endfunction
    task automatic test_done();
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_dots(input logic [7:0] e);
        cmp("dots", e, {3'h0, disp_dots_o});
    endtask
    task automatic poll_chk();
        host_u.poll(ok, q);
        if (!ok) begin
            mismatches++;
            test_done();
        end
    endtask
    task automatic wr(input logic rs, input logic [7:0] d);
        poll_chk();
        host_u.op(1'b1, rs, d, q);
    endtask
    task automatic show(input logic [7:0] c, input int l, input logic cur);
        @(posedge clk_sys_i);
        disp_code_i <= c;
        disp_line_i <= 3'(l);
        disp_cursor_i <= cur;
        font_row_i <= 5'h0a;
        @(posedge clk_sys_i);
        #1;
    endtask
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        serial_select_strap_i <= 1'b1;
        host_u.op(1'b1, 1'b1, 8'h1f, q);
        cmp("serial", 8'h01, {7'h00, serial_mode_o});
        @(posedge clk_sys_i);
        serial_select_strap_i <= 1'b0;
        poll_chk();
        cmp("acc", 8'h00, q);
        wr(1'b0, 8'h68);
        for (int i = 0; i < 8; i++) wr(1'b1, pat(i));
        poll_chk();
        cmp("acc", 8'h30, q);
        for (int i = 0; i < 8; i++) begin
            show(i[0] ? 8'h0d : 8'h05, i, 1'b0);
            cmp_dots(pat(i));
        end
        show(8'h05, 7, 1'b1);
        cmp_dots(8'h1f);
        for (int k = 0; k < 4; k++) begin
            show(8'h15 << k, 2, 1'b0);
            cmp_dots(8'h0a);
        end
        // first data byte lands while still busy and is dropped
        wr(1'b0, 8'h68);
        host_u.op(1'b1, 1'b1, 8'h03, q);
        host_u.op(1'b1, 1'b1, 8'h1c, q);
        poll_chk();
        cmp("acc", 8'h29, q);
        show(8'h05, 0, 1'b0);
        cmp_dots(8'h1c);
        poll_chk();
        host_u.op(1'b0, 1'b1, 8'h00, q);
        cmp("data", 8'h0e, q);
        poll_chk();
        cmp("acc", 8'h2a, q);
        wr(1'b0, 8'h4f);
        wr(1'b1, 8'h00);
        show(8'h01, 7, 1'b0);
        cmp_dots(8'h00);
        show(8'h09, 7, 1'b1);
        cmp_dots(8'h1f);
        wr(1'b0, 8'h20);
        host_u.narrow = 1'b1;
        wr(1'b0, 8'h53);
        wr(1'b1, 8'h1e);
        wr(1'b0, 8'h04);
        wr(1'b1, 8'h07);
        poll_chk();
        cmp("acc", 8'h13, q);
        show(8'h0a, 3, 1'b0);
        cmp_dots(8'h1e);
        show(8'h02, 4, 1'b0);
        cmp_dots(8'h07);
        // a stray high nibble, then reset: phase must restart at high
        host_u.xfer(1'b1, 1'b1, 8'hf5, q);
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        host_u.narrow = 1'b0;
        poll_chk();
        cmp("acc", 8'h00, q);
        wr(1'b0, 8'h20);
        host_u.narrow = 1'b1;
        wr(1'b0, 8'h53);
        poll_chk();
        cmp("acc", 8'h13, q);
        test_done();
    end
endmodule // tb
